/* File: dwm_pkg.sv */
package dwm_pkg;
  // ------------------------------------------------------------------
  // register offsets (byte addresses, one aligned word each)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_POS_ON    = 8'h08;
  localparam logic [7:0] OFS_POS_OFF   = 8'h0c;
  localparam logic [7:0] OFS_TEMP      = 8'h10;
  localparam logic [7:0] OFS_OVOLT     = 8'h14;
  localparam logic [7:0] OFS_UVOLT     = 8'h18;
  localparam logic [7:0] OFS_OVLD_TIME = 8'h1c;
  localparam logic [7:0] OFS_SPEED     = 8'h20;
  localparam logic [7:0] OFS_RESOL     = 8'h24;
  localparam logic [7:0] OFS_HIST_CMD  = 8'h28;
  localparam logic [7:0] OFS_HIST_DATA = 8'h2c;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h30;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h34;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h38;
  // ------------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------------
  localparam int CTRL_AUTO_RET  = 0;
  localparam int CTRL_ABS_BACK  = 1;
  localparam int CTRL_BRAKE_FIT = 2;
  localparam int HCMD_CLEAR     = 8;
  // ------------------------------------------------------------------
  // warning and alarm codes
  // ------------------------------------------------------------------
  localparam logic [7:0] WCODE_POS_ON  = 8'h10;
  localparam logic [7:0] WCODE_POS_OFF = 8'h12;
  localparam logic [7:0] WCODE_HEAT    = 8'h21;
  localparam logic [7:0] WCODE_OVOLT   = 8'h22;
  localparam logic [7:0] WCODE_UVOLT   = 8'h25;
  localparam logic [7:0] WCODE_OVLD    = 8'h30;
  localparam logic [7:0] WCODE_SPEED   = 8'h31;
  localparam logic [7:0] WCODE_BATT    = 8'h48;
  localparam int         NUM_WARN      = 8;
  localparam int         HIST_DEPTH    = 10;
  localparam logic [15:0] RESOL_MIN    = 16'd100;
  localparam logic [15:0] RESOL_MAX    = 16'd10000;
  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] RST_THRESH   = 32'hffff_ffff;
  localparam logic [31:0] RST_LOW      = 32'h0000_0000;
  localparam logic [15:0] RST_RESOL    = 16'd1000;
  localparam logic [2:0]  RST_CTRL     = 3'h0;
endpackage

/* File: dwm_sync.sv */
module dwm_sync import dwm_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         pclk,    // clock
  input  wire logic         presetn, // async reset, low
  input  wire logic [W-1:0] async_i, // asynchronous level
  output logic      [W-1:0] sync_o   // synchronised level
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

/* File: dwm_hist.sv */
module dwm_hist import dwm_pkg::*; #(
  parameter int DEPTH = HIST_DEPTH
) (
  input  wire logic       pclk,     // clock
  input  wire logic       presetn,  // async reset, low
  input  wire logic       push,     // store new code
  input  wire logic [7:0] code,     // code to store
  input  wire logic       clear,    // empty history
  input  wire logic [3:0] rd_idx,   // 0 = newest
  output logic      [7:0] rd_code,  // entry at rd_idx
  output logic      [4:0] count     // valid entries
);
  logic [7:0] ent_q [DEPTH];
  logic [4:0] cnt_q;

  // ------------------------------------------------------------------
  // shift register, newest at index 0
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ent_q[g] <= 8'h00;
        end else if (clear) begin
          ent_q[g] <= 8'h00;
        end else if (push) begin
          if (g == 0) ent_q[g] <= code;
          else        ent_q[g] <= ent_q[g-1];
        end
      end
    end
  endgenerate

  // clear wins over push: a code raised in the clearing cycle is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 5'd0;
    else if (clear) cnt_q <= 5'd0;
    else if (push && cnt_q < 5'(DEPTH)) cnt_q <= cnt_q + 5'd1;
  end

  assign count   = cnt_q;
  assign rd_code = (32'(rd_idx) < DEPTH && 5'(rd_idx) < cnt_q) ? ent_q[rd_idx] : 8'h00;
endmodule

/* File: dwm_top.sv */
module dwm_top import dwm_pkg::*; (
  input  wire logic        pclk,             // 40 MHz clock
  input  wire logic        presetn,          // async reset, low
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb enable
  input  wire logic        pwrite,           // apb write
  input  wire logic [7:0]  paddr,            // apb byte address
  input  wire logic [31:0] pwdata,           // apb write data
  output logic      [31:0] prdata,           // apb read data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error
  input  wire logic [31:0] pos_dev,          // position deviation magnitude
  input  wire logic        current_on,       // motor current on
  input  wire logic [31:0] drive_temp,       // internal temperature
  input  wire logic [31:0] supply_volt,      // supply voltage
  input  wire logic        peak_overload,    // load above peak torque
  input  wire logic [31:0] shaft_speed,      // output shaft speed
  input  wire logic        battery_present,  // backup battery pin
  input  wire logic        alarm_clear_in,   // alarm reset pin
  input  wire logic        link_rate_valid,  // rate switch in range pin
  input  wire logic        exc_alarm_in,     // resettable excitation alarm
  input  wire logic        nexc_alarm_in,    // resettable non-excitation alarm
  output logic             warning_out,      // warning active
  output logic             alarm_out,        // any alarm active
  output logic             motor_current_en, // motor current allowed
  output logic             brake_engage,     // brake hold
  output logic             irq               // interrupt level
);
  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [2:0] pins_s;
  dwm_sync #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i ({battery_present, alarm_clear_in, link_rate_valid}),
    .sync_o  (pins_s)
  );
  logic batt_s;
  logic aclr_s;
  logic rate_ok_s;
  assign batt_s    = pins_s[2];
  assign aclr_s    = pins_s[1];
  assign rate_ok_s = pins_s[0];

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  logic [2:0]  ctrl_q;
  logic [31:0] pos_on_q;
  logic [31:0] pos_off_q;
  logic [31:0] temp_q;
  logic [31:0] ovolt_q;
  logic [31:0] uvolt_q;
  logic [31:0] ovld_q;
  logic [31:0] speed_q;
  logic [15:0] resol_q;
  logic [3:0]  rd_idx_q;
  logic [NUM_WARN-1:0] irq_stat_q;
  logic [NUM_WARN-1:0] irq_en_q;

  // pready is tied high: every register answers in its access cycle
  logic wr_en;
  logic rd_en;
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;

  logic addr_ok;
  always_comb begin
    unique case (paddr)
      OFS_CTRL,
      OFS_STATUS,
      OFS_POS_ON,
      OFS_POS_OFF,
      OFS_TEMP,
      OFS_OVOLT,
      OFS_UVOLT,
      OFS_OVLD_TIME,
      OFS_SPEED,
      OFS_RESOL,
      OFS_HIST_CMD,
      OFS_HIST_DATA,
      OFS_IRQ_STAT,
      OFS_IRQ_EN,
      OFS_IRQ_CLR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= RST_CTRL;
      pos_on_q  <= RST_THRESH;
      pos_off_q <= RST_THRESH;
      temp_q    <= RST_THRESH;
      ovolt_q   <= RST_THRESH;
      uvolt_q   <= RST_LOW;
      ovld_q    <= RST_THRESH;
      speed_q   <= RST_THRESH;
      irq_en_q  <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_CTRL:      ctrl_q    <= pwdata[2:0];
        OFS_POS_ON:    pos_on_q  <= pwdata;
        OFS_POS_OFF:   pos_off_q <= pwdata;
        OFS_TEMP:      temp_q    <= pwdata;
        OFS_OVOLT:     ovolt_q   <= pwdata;
        OFS_UVOLT:     uvolt_q   <= pwdata;
        OFS_OVLD_TIME: ovld_q    <= pwdata;
        OFS_SPEED:     speed_q   <= pwdata;
        OFS_IRQ_EN:    irq_en_q  <= pwdata[NUM_WARN-1:0];
        default: ;
      endcase
    end
  end

  // the gear check watches this value at all times; once tripped, only
  // presetn (a power cycle) lets a corrected setting run the motor again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) resol_q <= RST_RESOL;
    else if (wr_en && paddr == OFS_RESOL) resol_q <= pwdata[15:0];
  end

  // ------------------------------------------------------------------
  // warning detection
  // ------------------------------------------------------------------
  // saturates, so a load held for ages still reads as overloaded
  logic [31:0] ovld_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ovld_cnt_q <= 32'd0;
    else if (!peak_overload) ovld_cnt_q <= 32'd0;
    else if (ovld_cnt_q != 32'hffff_ffff) ovld_cnt_q <= ovld_cnt_q + 32'd1;
  end

  logic [NUM_WARN-1:0] cause;
  assign cause[0] = current_on && pos_dev > pos_on_q;
  assign cause[1] = !current_on && ctrl_q[CTRL_AUTO_RET] && pos_dev > pos_off_q;
  assign cause[2] = drive_temp > temp_q;
  assign cause[3] = supply_volt > ovolt_q;
  assign cause[4] = supply_volt < uvolt_q;
  assign cause[5] = peak_overload && ovld_cnt_q >= ovld_q;
  assign cause[6] = shaft_speed > speed_q;
  assign cause[7] = ctrl_q[CTRL_ABS_BACK] && !batt_s;

  localparam logic [7:0] CODES [NUM_WARN] = '{
    WCODE_POS_ON,
    WCODE_POS_OFF,
    WCODE_HEAT,
    WCODE_OVOLT,
    WCODE_UVOLT,
    WCODE_OVLD,
    WCODE_SPEED,
    WCODE_BATT
  };

  logic [NUM_WARN-1:0] cause_q, rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cause_q <= '0;
    else cause_q <= cause;
  end
  assign rise = cause & ~cause_q;

  // only the lowest pending cause is logged per cycle; the rest stay
  // pending and log one per later cycle, lowest first
  logic [NUM_WARN-1:0] pend_q;
  logic [NUM_WARN-1:0] pend_all;
  logic                push;
  logic [7:0]          push_code;
  logic [NUM_WARN-1:0] push_sel;
  assign pend_all = pend_q | rise;
  always_comb begin
    push      = 1'b0;
    push_code = 8'h00;
    push_sel  = '0;
    for (int i = NUM_WARN - 1; i >= 0; i--) begin
      if (pend_all[i]) begin
        push      = 1'b1;
        push_code = CODES[i];
        push_sel  = NUM_WARN'(1) << i;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pend_q <= '0;
    else pend_q <= pend_all & ~push_sel;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) warning_out <= 1'b0;
    else warning_out <= |cause;
  end

  // ------------------------------------------------------------------
  // history
  // ------------------------------------------------------------------
  logic       hist_clear;
  logic [7:0] hist_code;
  logic [4:0] hist_cnt;
  // a clear write also loads the read index from pwdata[3:0]; zero there restarts reads at newest
  assign hist_clear = wr_en && paddr == OFS_HIST_CMD && pwdata[HCMD_CLEAR];
  dwm_hist #(.DEPTH(HIST_DEPTH)) u_hist (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (push),
    .code    (push_code),
    .clear   (hist_clear),
    .rd_idx  (rd_idx_q),
    .rd_code (hist_code),
    .count   (hist_cnt)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rd_idx_q <= 4'd0;
    else if (wr_en && paddr == OFS_HIST_CMD) rd_idx_q <= pwdata[3:0];
  end

  // ------------------------------------------------------------------
  // alarms
  // ------------------------------------------------------------------
  logic gear_alm_q;
  logic rate_alm_q;
  logic exc_alm_q;
  logic nexc_alm_q;
  logic aclr_d1_q;
  logic aclr_fall;

  // the edge register idles low like the pin, so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) aclr_d1_q <= 1'b0;
    else aclr_d1_q <= aclr_s;
  end
  assign aclr_fall = aclr_d1_q && !aclr_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gear_alm_q <= 1'b0;
    else if (resol_q < RESOL_MIN || resol_q > RESOL_MAX)
      gear_alm_q <= 1'b1;
  end

  // rate switch is caught a few cycles after release, once synchronised
  logic [1:0] rate_wait_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rate_wait_q <= 2'd0;
    else if (rate_wait_q != 2'd3) rate_wait_q <= rate_wait_q + 2'd1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rate_alm_q <= 1'b0;
    else if (rate_wait_q == 2'd2 && !rate_ok_s) rate_alm_q <= 1'b1;
  end

  // set wins over the clearing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_alm_q  <= 1'b0;
      nexc_alm_q <= 1'b0;
    end else begin
      if (exc_alarm_in) exc_alm_q <= 1'b1;
      else if (aclr_fall) exc_alm_q <= 1'b0;
      if (nexc_alarm_in) nexc_alm_q <= 1'b1;
      else if (aclr_fall) nexc_alm_q <= 1'b0;
    end
  end

  logic nexc_any;
  assign nexc_any = gear_alm_q || rate_alm_q || nexc_alm_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_out        <= 1'b0;
      motor_current_en <= 1'b0;
      brake_engage     <= 1'b0;
    end else begin
      alarm_out        <= nexc_any || exc_alm_q;
      motor_current_en <= !nexc_any;
      brake_engage     <= nexc_any && ctrl_q[CTRL_BRAKE_FIT];
    end
  end

  // ------------------------------------------------------------------
  // interrupts: write-one-to-clear, a new edge wins over the clear
  // ------------------------------------------------------------------
  logic [NUM_WARN-1:0] irq_clr;
  assign irq_clr = (wr_en && paddr == OFS_IRQ_CLR) ? pwdata[NUM_WARN-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_stat_q <= '0;
    else irq_stat_q <= rise | (irq_stat_q & ~irq_clr);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else irq <= |(irq_stat_q & irq_en_q);
  end

  // ------------------------------------------------------------------
  // read data, registered in the setup cycle
  // ------------------------------------------------------------------
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0;
    unique case (paddr)
      OFS_CTRL:      rd_d = {29'h0, ctrl_q};
      OFS_STATUS:    rd_d = {16'h0, NUM_WARN'(cause), 3'h0, hist_cnt[4:0] & 5'h1f} |
                            {28'h0, gear_alm_q, rate_alm_q, exc_alm_q, nexc_alm_q} << 24;
      OFS_POS_ON:    rd_d = pos_on_q;
      OFS_POS_OFF:   rd_d = pos_off_q;
      OFS_TEMP:      rd_d = temp_q;
      OFS_OVOLT:     rd_d = ovolt_q;
      OFS_UVOLT:     rd_d = uvolt_q;
      OFS_OVLD_TIME: rd_d = ovld_q;
      OFS_SPEED:     rd_d = speed_q;
      OFS_RESOL:     rd_d = {16'h0, resol_q};
      OFS_HIST_CMD:  rd_d = {28'h0, rd_idx_q};
      OFS_HIST_DATA: rd_d = {24'h0, hist_code};
      OFS_IRQ_STAT:  rd_d = {24'h0, irq_stat_q};
      OFS_IRQ_EN:    rd_d = {24'h0, irq_en_q};
      default:       rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (rd_en) prdata <= rd_d;
  end
endmodule

/* File: dwm_assertions.sv */
module dwm_assertions import dwm_pkg::*; (
  input wire logic       pclk,             // clock
  input wire logic       presetn,          // reset, low
  input wire logic       psel,             // select
  input wire logic       penable,          // enable
  input wire logic       pwrite,           // write
  input wire logic [7:0] paddr,            // address
  input wire logic       pready,           // ready
  input wire logic       pslverr,          // error
  input wire logic       alarm_clear_in,   // clear pin
  input wire logic       exc_alarm_in,     // exc alarm
  input wire logic       nexc_alarm_in,    // nexc alarm
  input wire logic       warning_out,      // warning
  input wire logic       alarm_out,        // alarm
  input wire logic       motor_current_en, // current
  input wire logic       brake_engage,     // brake
  input wire logic       irq               // interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_err_map; psel && penable && paddr > OFS_IRQ_CLR |-> pslverr; endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped not refused");
  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  // ------------------------------------------------------------
  // warnings and alarms
  // ------------------------------------------------------------
  property p_warn_run;
    warning_out && motor_current_en && !nexc_alarm_in |=> motor_current_en;
  endproperty
  a_warn_run: assert property (p_warn_run) else $error("warning cut current");
  property p_irq_cause;
    $rose(irq) |-> $past(warning_out) || $past(psel && penable && pwrite, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
  property p_nexc_cut; nexc_alarm_in |-> ##2 !motor_current_en && alarm_out; endproperty
  a_nexc_cut: assert property (p_nexc_cut) else $error("nexc kept current");
  property p_brake; brake_engage |-> !motor_current_en; endproperty
  a_brake: assert property (p_brake) else $error("brake with current");
  property p_exc_keep;
    exc_alarm_in && !nexc_alarm_in && motor_current_en |-> ##2 motor_current_en && alarm_out;
  endproperty
  a_exc_keep: assert property (p_exc_keep) else $error("exc cut current");
  // a quiet pin for six cycles means the synced edge has long passed
  sequence s_quiet; !alarm_clear_in && !exc_alarm_in && !nexc_alarm_in; endsequence
  sequence s_pulse; alarm_clear_in ##1 s_quiet [*6]; endsequence
  property p_hold; s_quiet [*6] ##0 alarm_out |=> alarm_out; endproperty
  a_hold: assert property (p_hold) else $error("alarm dropped alone");
  property p_clear; s_pulse ##0 motor_current_en |=> !alarm_out; endproperty
  a_clear: assert property (p_clear) else $error("alarm not cleared");
endmodule

bind dwm_top dwm_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pready, .pslverr, .alarm_clear_in, .exc_alarm_in, .nexc_alarm_in, .warning_out,
  .alarm_out, .motor_current_en, .brake_engage, .irq);

/* File: dwm_host.sv */
module dwm_host import dwm_pkg::*; (
  input  wire logic        pclk,    // clock
  output logic             psel,    // select
  output logic             penable, // enable
  output logic             pwrite,  // write
  output logic      [7:0]  paddr,   // address
  output logic      [31:0] pwdata,  // write data
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pready,  // ready
  input  wire logic        pslverr  // error
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rdata;
  logic        err;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // released address and data show the inverse; pwrite keeps its last value
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic hist_read(input logic [3:0] i);
    xfer(1'b1, OFS_HIST_CMD, {28'h0, i});
    xfer(1'b0, OFS_HIST_DATA, 32'h0);
  endtask
  task automatic hist_clear();
    xfer(1'b1, OFS_HIST_CMD, 32'h1 << HCMD_CLEAR);
  endtask
endmodule

/* File: dwm_tb_top.sv */
module dwm_tb_top import dwm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, current_on;
  logic        peak_overload, battery_present, alarm_clear_in, link_rate_valid;
  logic        exc_alarm_in, nexc_alarm_in, warning_out, alarm_out, motor_current_en;
  logic        brake_engage, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pos_dev, drive_temp, supply_volt, shaft_speed;
  int          bad_count, samples_checked;
  logic [7:0]  codes [8] = '{WCODE_POS_ON, WCODE_POS_OFF, WCODE_HEAT, WCODE_OVOLT,
                             WCODE_UVOLT, WCODE_OVLD, WCODE_SPEED, WCODE_BATT};
  dwm_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pos_dev, .current_on, .drive_temp, .supply_volt, .peak_overload,
    .shaft_speed, .battery_present, .alarm_clear_in, .link_rate_valid, .exc_alarm_in,
    .nexc_alarm_in, .warning_out, .alarm_out, .motor_current_en, .brake_engage, .irq);
  dwm_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  always #12.5 pclk = ~pclk;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic cyc(input int n); repeat (n) @(posedge pclk); endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); host.xfer(1'b1, a, d); endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    host.xfer(1'b0, a, 32'h0);
    chk(host.rdata, e, m);
  endtask
  task automatic done(input string n); $display("test %s done, bad %0d", n, bad_count); endtask
  task automatic cause(input int k, input logic on);
    case (k)
      0: pos_dev <= on ? 32'h65 : 32'h0;
      1: begin current_on <= !on; pos_dev <= on ? 32'h65 : 32'h0; end
      2: drive_temp <= on ? 32'h33 : 32'h0;
      3: supply_volt <= on ? 32'h12d : 32'hfa;
      4: supply_volt <= on ? 32'hc7 : 32'hfa;
      5: peak_overload <= on;
      6: shaft_speed <= on ? 32'h3e9 : 32'h0;
      default: battery_present <= !on;
    endcase
  endtask
  task automatic blip(input int k); cause(k, 1'b1); cyc(3); cause(k, 1'b0); cyc(3); endtask
  // holds the pin a while so a rising edge alone is seen not to clear
  task automatic pulse();
    alarm_clear_in <= 1'b1;
    cyc(3);
    chk(alarm_out, 1'b1, "cleared on rise");
    alarm_clear_in <= 1'b0;
    cyc(6);
  endtask
  task automatic do_reset(input logic rate_ok);
    link_rate_valid <= rate_ok;
    presetn <= 1'b0;
    cyc(4);
    presetn <= 1'b1;
    cyc(6);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rd(OFS_STATUS, 32'h0, "status");
    rd(OFS_RESOL, 32'h3e8, "resol");
    rd(OFS_POS_ON, RST_THRESH, "pos thr");
    rd(OFS_UVOLT, RST_LOW, "uv thr");
    wr(OFS_STATUS, 32'hffff_ffff);
    rd(OFS_STATUS, 32'h0, "ro status");
    host.xfer(1'b0, 8'h3c, 32'h0);
    chk({31'h0, host.err}, 32'h1, "unmapped err");
    chk({warning_out, alarm_out, motor_current_en}, 3'b001, "idle outs");
    done("regs");
  endtask
  task automatic t_warn();
    wr(OFS_POS_ON, 32'h64);
    wr(OFS_POS_OFF, 32'h64);
    wr(OFS_TEMP, 32'h32);
    wr(OFS_OVOLT, 32'h12c);
    wr(OFS_UVOLT, 32'hc8);
    wr(OFS_OVLD_TIME, 32'h5);
    wr(OFS_SPEED, 32'h3e8);
    drive_temp <= 32'h32;
    wr(OFS_CTRL, 32'h2);
    cause(1, 1'b1);
    cyc(4);
    chk(warning_out, 1'b0, "equal or no autoret");
    cause(1, 1'b0);
    drive_temp <= 32'h0;
    wr(OFS_CTRL, 32'h3);
    for (int k = 0; k < NUM_WARN; k++) begin
      cause(k, 1'b1);
      cyc(8);
      chk(warning_out, 1'b1, "warn on");
      chk(motor_current_en, 1'b1, "motor kept");
      cause(k, 1'b0);
      cyc(4);
      chk(warning_out, 1'b0, "warn off");
    end
    repeat (3) blip(2);
    rd(OFS_STATUS, 32'ha, "count full");
    for (int i = 0; i < 11; i++) begin
      host.hist_read(4'(i));
      chk(host.rdata, i > 9 ? 32'h0 : {24'h0, codes[i < 3 ? 2 : 10-i]}, "hist");
    end
    host.hist_clear();
    rd(OFS_STATUS, 32'h0, "cleared");
    host.hist_read(4'h0);
    chk(host.rdata, 32'h0, "empty");
    done("warn");
  endtask
  task automatic t_irq();
    wr(OFS_IRQ_CLR, 32'hff);
    wr(OFS_IRQ_EN, 32'h4);
    rd(OFS_IRQ_EN, 32'h4, "irq en");
    blip(6);
    chk(irq, 1'b0, "masked");
    rd(OFS_IRQ_STAT, 32'h40, "sticky");
    blip(2);
    chk(irq, 1'b1, "enabled");
    wr(OFS_IRQ_CLR, 32'h4);
    cyc(2);
    chk(irq, 1'b0, "after clear");
    rd(OFS_IRQ_STAT, 32'h40, "stat left");
    done("irq");
  endtask
  task automatic t_alarm();
    exc_alarm_in <= 1'b1;
    cyc(1);
    exc_alarm_in <= 1'b0;
    cyc(2);
    chk({alarm_out, motor_current_en}, 2'b11, "exc alarm");
    pulse();
    chk(alarm_out, 1'b0, "exc cleared");
    for (int b = 1; b >= 0; b--) begin
      wr(OFS_CTRL, 32'(b) << CTRL_BRAKE_FIT);
      nexc_alarm_in <= 1'b1;
      cyc(1);
      nexc_alarm_in <= 1'b0;
      cyc(2);
      chk({alarm_out, motor_current_en, brake_engage}, {2'b10, 1'(b)}, "nexc");
      pulse();
      chk({alarm_out, motor_current_en, brake_engage}, 3'b010, "nexc cleared");
    end
    done("alarm");
  endtask
  task automatic t_power();
    blip(2);
    do_reset(1'b0);
    rd(OFS_STATUS, 32'h0400_0000, "after power");
    chk({alarm_out, motor_current_en}, 2'b10, "rate alarm");
    wr(OFS_CTRL, 32'h4);
    cyc(2);
    chk(brake_engage, 1'b1, "brake");
    pulse();
    link_rate_valid <= 1'b1;
    cyc(4);
    chk(alarm_out, 1'b1, "not resettable");
    do_reset(1'b1);
    chk({alarm_out, motor_current_en}, 2'b01, "power cycled");
    wr(OFS_RESOL, 32'h2710);
    rd(OFS_STATUS, 32'h0, "gear edge");
    wr(OFS_RESOL, 32'h63);
    rd(OFS_STATUS, 32'h0800_0000, "gear alarm");
    pulse();
    chk({alarm_out, motor_current_en}, 2'b10, "gear kept");
    do_reset(1'b1);
    chk(alarm_out, 1'b0, "gear power cycled");
    done("power");
  endtask
  initial begin
    {pclk, presetn, peak_overload, alarm_clear_in, exc_alarm_in, nexc_alarm_in} = '0;
    {current_on, battery_present, link_rate_valid} = 3'b111;
    {pos_dev, drive_temp, shaft_speed} = '0;
    supply_volt = 32'hfa;
    do_reset(1'b1);
    t_regs();
    t_warn();
    t_irq();
    t_alarm();
    t_power();
    tally_and_finish();
  end
  initial begin
    #1000000;
    bad_count++;
    $display("BAD %0t timeout", $time);
    tally_and_finish();
  end
endmodule
